// file: design/les_pkg.sv
package les_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned LES_CLK_HZ = 100_000_000;
  localparam int unsigned LES_ENABLE_WAIT_S = 5;
  localparam longint unsigned LES_ENABLE_WAIT_CYC = longint'(LES_ENABLE_WAIT_S) * LES_CLK_HZ;
  localparam int unsigned LES_FILTER_NS = 1000;
  localparam int unsigned LES_FILTER_CYC = (LES_FILTER_NS * (LES_CLK_HZ / 1_000_000)) / 1000;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LES_CTRL_OFS = 8'h00;
  localparam logic [7:0] LES_STAT_OFS = 8'h04;
  localparam int unsigned LES_CTRL_SWINH_BIT = 0;
  localparam int unsigned LES_CTRL_OVT_CLR_BIT = 1;
  localparam logic [31:0] LES_CTRL_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LES_ST_OFF,
    LES_ST_WAIT,
    LES_ST_READY,
    LES_ST_FAULT
  } les_state_e;

  typedef struct packed {
    logic interlock;
    logic shutter_req;
    logic reset_req;
    logic over_temp;
  } les_in_s;

  typedef struct packed {
    logic ready_lamp;
    logic shutter_lamp;
    logic intlk_lamp_green;
    logic ready_closed;
    logic shutter_closed;
    logic intlk_open_closed;
  } les_stat_s;

endpackage : les_pkg

// file: design/les_sequencer.sv
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
module les_sequencer
  import les_pkg::*;
#(
  parameter longint unsigned ENABLE_WAIT_CYC = LES_ENABLE_WAIT_CYC,
  parameter int unsigned FILTER_CYC = LES_FILTER_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Discrete user inputs (asynchronous pins)
  input wire logic i_interlock,
  input wire logic i_shutter_req,
  input wire logic i_reset_req,
  input wire logic i_over_temp,
  // Pulse sources (asynchronous pins)
  input wire logic i_pwm_cmd,
  input wire logic i_keep_alive,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Power and pulse outputs
  output logic o_rf_power_en,
  output logic o_rf_drive,
  output logic o_shutter_open,
  // Lamps and status contacts (1 = lit or closed)
  output logic o_ready_lamp,
  output logic o_shutter_lamp,
  output logic o_intlk_lamp_green,
  output logic o_ready_closed,
  output logic o_shutter_closed,
  output logic o_intlk_open_closed
);

  localparam int NIN = 6;
  localparam int FW = $clog2(FILTER_CYC + 1) + 1;
  localparam int TW = $clog2(ENABLE_WAIT_CYC + 1) + 1;

  // ----------------------------------------------------------------
  // Input synchronisers and glitch filters
  // ----------------------------------------------------------------
  logic [NIN-1:0] sync1_reg;
  logic [NIN-1:0] sync2_reg;
  logic [NIN-1:0] filt_reg;
  logic [FW-1:0] fcnt_reg [NIN-2];
  les_in_s in_f;
  logic pwm_s;
  logic keep_s;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {i_keep_alive, i_pwm_cmd, i_interlock, i_shutter_req, i_reset_req,
                    i_over_temp};
      sync2_reg <= sync1_reg;
    end
  end

  // Level inputs need a stable run; pulse inputs only pass the synchroniser,
  // since filtering them would eat short PWM pulses.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      filt_reg <= '0;
      for (int k = 0; k < NIN - 2; k++) fcnt_reg[k] <= '0;
    end else begin
      for (int k = 0; k < NIN - 2; k++) begin
        if (sync2_reg[k] == filt_reg[k]) begin
          fcnt_reg[k] <= '0;
        end else if (fcnt_reg[k] >= FW'(FILTER_CYC)) begin
          filt_reg[k] <= sync2_reg[k];
          fcnt_reg[k] <= '0;
        end else begin
          fcnt_reg[k] <= fcnt_reg[k] + FW'(1);
        end
      end
      filt_reg[NIN-1:NIN-2] <= sync2_reg[NIN-1:NIN-2];
    end
  end

  assign in_f.over_temp = filt_reg[0];
  assign in_f.reset_req = filt_reg[1];
  assign in_f.shutter_req = filt_reg[2];
  assign in_f.interlock = filt_reg[3];
  assign pwm_s = filt_reg[4];
  assign keep_s = filt_reg[5];

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic apb_wr;
  logic sw_inhibit;
  logic inhibit;
  les_stat_s stat;
  les_state_e state_reg;
  logic ovt_latch_reg;
  logic apb_setup;

  // Address decode is shared by the write path and the read mux.
  function automatic logic les_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction : les_hit

  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign apb_setup = i_psel && !i_penable;
  assign sw_inhibit = ctrl_reg[LES_CTRL_SWINH_BIT];

  // Software inhibit is the only writable bit; the over-temperature latch
  // has no clear bit on purpose, so software cannot defeat it.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_reg <= LES_CTRL_RST;
    end else if (apb_wr && les_hit(i_paddr, LES_CTRL_OFS)) begin
      ctrl_reg <= {30'h0, 1'b0, i_pwdata[LES_CTRL_SWINH_BIT]};
    end
  end

  // Every access is answered one cycle after its setup cycle.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= apb_setup;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= apb_setup && !les_hit(i_paddr, LES_CTRL_OFS)
                   && !les_hit(i_paddr, LES_STAT_OFS);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      if (les_hit(i_paddr, LES_CTRL_OFS)) begin
        o_prdata <= ctrl_reg;
      end else if (les_hit(i_paddr, LES_STAT_OFS)) begin
        o_prdata <= {20'h0, 1'(ovt_latch_reg), 3'(state_reg), 2'h0, stat};
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end else begin
      o_prdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Over-temperature latch
  // ----------------------------------------------------------------
  // Only the power-on reset clears this; no input or register write can.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ovt_latch_reg <= 1'b0;
    end else if (in_f.over_temp) begin
      ovt_latch_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Enable state machine and five-second timer
  // ----------------------------------------------------------------
  logic [TW-1:0] tmr_reg;
  logic tmr_done;

  assign inhibit = in_f.reset_req || sw_inhibit;
  assign tmr_done = (tmr_reg >= TW'(ENABLE_WAIT_CYC - 1));

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= LES_ST_OFF;
    end else begin
      case (state_reg)
        LES_ST_OFF: begin
          if (ovt_latch_reg) begin
            state_reg <= LES_ST_FAULT;
          end else if (in_f.interlock && !inhibit) begin
            state_reg <= LES_ST_WAIT;
          end
        end
        LES_ST_WAIT: begin
          if (ovt_latch_reg) begin
            state_reg <= LES_ST_FAULT;
          end else if (!in_f.interlock || inhibit) begin
            state_reg <= LES_ST_OFF;
          end else if (tmr_done) begin
            state_reg <= LES_ST_READY;
          end
        end
        LES_ST_READY: begin
          if (ovt_latch_reg) begin
            state_reg <= LES_ST_FAULT;
          end else if (!in_f.interlock || inhibit) begin
            state_reg <= LES_ST_OFF;
          end
        end
        LES_ST_FAULT: begin
          state_reg <= LES_ST_FAULT;
        end
        default: begin
          state_reg <= LES_ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Enable countdown
  // ----------------------------------------------------------------
  // The count restarts from zero whenever the wait is left, so an interlock drop
  // that outlasts the filter always costs a full countdown before power returns.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tmr_reg <= '0;
    end else if (state_reg == LES_ST_WAIT && in_f.interlock && !inhibit && !ovt_latch_reg
                 && !tmr_done) begin
      tmr_reg <= tmr_reg + TW'(1);
    end else begin
      tmr_reg <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Lamps, status contacts and power gating
  // ----------------------------------------------------------------
  // The ready lamp lights as soon as the interlock closes with no inhibit and no over-temperature latched, during the wait.
  logic ready_on;
  logic lase_ok;
  logic rf_on;

  assign ready_on = (state_reg == LES_ST_WAIT) || (state_reg == LES_ST_READY);
  assign lase_ok = (state_reg == LES_ST_READY) && in_f.interlock && !inhibit;
  assign rf_on = lase_ok && in_f.interlock;

  assign stat.ready_lamp = ready_on;
  assign stat.shutter_lamp = in_f.shutter_req && lase_ok;
  assign stat.intlk_lamp_green = in_f.interlock;
  assign stat.ready_closed = lase_ok;
  assign stat.shutter_closed = in_f.shutter_req && lase_ok;
  assign stat.intlk_open_closed = !in_f.interlock;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ready_lamp <= 1'b0;
      o_shutter_lamp <= 1'b0;
      o_intlk_lamp_green <= 1'b0;
    end else begin
      o_ready_lamp <= stat.ready_lamp;
      o_shutter_lamp <= stat.shutter_lamp;
      o_intlk_lamp_green <= stat.intlk_lamp_green;
    end
  end

  // ----------------------------------------------------------------
  // Status contacts
  // ----------------------------------------------------------------
  // The interlock-open contact rests closed in reset, since the loop has
  // not yet been seen closed through the filter.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ready_closed <= 1'b0;
      o_shutter_closed <= 1'b0;
      o_intlk_open_closed <= 1'b1;
    end else begin
      o_ready_closed <= stat.ready_closed;
      o_shutter_closed <= stat.shutter_closed;
      o_intlk_open_closed <= stat.intlk_open_closed;
    end
  end

  // ----------------------------------------------------------------
  // Power and pulse gating
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rf_power_en <= 1'b0;
    end else begin
      o_rf_power_en <= rf_on;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_shutter_open <= 1'b0;
    end else begin
      o_shutter_open <= stat.shutter_lamp;
    end
  end

  // The source is picked each cycle; a request change in mid-pulse may
  // clip that one pulse, which is accepted for a simpler gate.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rf_drive <= 1'b0;
    end else if (!rf_on) begin
      o_rf_drive <= 1'b0;
    end else if (in_f.shutter_req) begin
      o_rf_drive <= pwm_s;
    end else begin
      o_rf_drive <= keep_s;
    end
  end

endmodule : les_sequencer

// file: sim/les_sequencer_properties.sv
`timescale 1ns/1ps
module les_sequencer_properties #(
  parameter longint unsigned ENABLE_WAIT_CYC = 100,
  parameter int unsigned FILTER_CYC = 3
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_interlock,
  input wire logic i_reset_req,
  input wire logic i_over_temp,
  input wire logic o_rf_power_en,
  input wire logic o_ready_lamp,
  input wire logic o_intlk_lamp_green,
  input wire logic o_ready_closed,
  input wire logic o_shutter_closed,
  input wire logic o_intlk_open_closed
);
  // Margin covers two sync flops, the filter and the registered outputs.
  localparam int T = FILTER_CYC + 8;
  int il_cnt, rr_cnt, ot_cnt, lamp_cnt;
  logic ot_seen;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      il_cnt <= 0;
      rr_cnt <= 0;
      ot_cnt <= 0;
      ot_seen <= 1'b0;
      lamp_cnt <= 0;
    end else begin
      il_cnt <= i_interlock ? 0 : il_cnt + int'(il_cnt < T);
      rr_cnt <= i_reset_req ? rr_cnt + int'(rr_cnt < T) : 0;
      ot_cnt <= i_over_temp ? ot_cnt + int'(ot_cnt < T) : 0;
      ot_seen <= ot_seen | (ot_cnt >= T);
      lamp_cnt <= (o_ready_lamp && !o_rf_power_en) ? lamp_cnt + 1 : 0;
    end
  end
  property p_wait_len;
    $rose(o_rf_power_en) |-> lamp_cnt >= ENABLE_WAIT_CYC - 3 && lamp_cnt <= ENABLE_WAIT_CYC + 3;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("power without full wait");
  property p_ovt_latch;
    ot_seen |-> !o_rf_power_en && !o_ready_closed;
  endproperty
  a_ovt_latch: assert property (p_ovt_latch) else $error("over-temp not held");
  property p_inhibit;
    rr_cnt >= T |-> !o_rf_power_en;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("power during inhibit");
  property p_ready_lamp;
    o_ready_closed |-> o_ready_lamp;
  endproperty
  a_ready_lamp: assert property (p_ready_lamp) else $error("ready contact without lamp");
  property p_shut_stat;
    o_shutter_closed |-> o_ready_closed;
  endproperty
  a_shut_stat: assert property (p_shut_stat) else $error("shutter status without ready");
  property p_power_cond;
    o_rf_power_en |-> o_intlk_lamp_green && o_ready_closed;
  endproperty
  a_power_cond: assert property (p_power_cond) else $error("power without loop or ready");
  property p_intlk_loss;
    il_cnt >= T |-> !o_ready_lamp && !o_intlk_lamp_green;
  endproperty
  a_intlk_loss: assert property (p_intlk_loss) else $error("lamps on with loop open");
  property p_intlk_stat;
    o_intlk_open_closed != o_intlk_lamp_green;
  endproperty
  a_intlk_stat: assert property (p_intlk_stat) else $error("interlock status wrong");
  c_power: cover property ($rose(o_rf_power_en));
  c_shut: cover property ($rose(o_shutter_closed));
  c_ovt: cover property ($rose(ot_seen));
endmodule : les_sequencer_properties

bind les_sequencer les_sequencer_properties #(
  .ENABLE_WAIT_CYC(ENABLE_WAIT_CYC),
  .FILTER_CYC(FILTER_CYC)
) u_props (
  .i_ref_clk(i_ref_clk),
  .i_rst_b(i_rst_b),
  .i_interlock(i_interlock),
  .i_reset_req(i_reset_req),
  .i_over_temp(i_over_temp),
  .o_rf_power_en(o_rf_power_en),
  .o_ready_lamp(o_ready_lamp),
  .o_intlk_lamp_green(o_intlk_lamp_green),
  .o_ready_closed(o_ready_closed),
  .o_shutter_closed(o_shutter_closed),
  .o_intlk_open_closed(o_intlk_open_closed)
);

// file: sim/les_ctrl_model.sv
`timescale 1ns/1ps
module les_ctrl_model
  import les_pkg::*;
(
  input wire logic i_ref_clk,
  output logic o_interlock,
  output logic o_shutter_req,
  output logic o_reset_req,
  output logic o_over_temp,
  output logic o_pwm_cmd,
  output logic o_keep_alive
);
  les_in_s lvl = '0;
  logic [1:0] pls = '0;
  assign {o_interlock, o_shutter_req, o_reset_req, o_over_temp} = lvl;
  assign {o_pwm_cmd, o_keep_alive} = pls;
  // Levels change only after an edge, as a machine controller would.
  task automatic drive(input les_in_s v, input logic [1:0] p);
    @(posedge i_ref_clk);
    lvl <= v;
    pls <= p;
  endtask : drive
endmodule : les_ctrl_model

// file: sim/les_sequencer_test.sv
`timescale 1ns/1ps
module les_sequencer_test;
  import les_pkg::*;
  localparam longint unsigned W = 100;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, e;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0, q, prdata;
  logic pready, pslverr, rfp, rfd, sho, rl, sl, gl, rc, sc, ic, il, sr, rr, ot, pwm, ka;
  int error_cnt = 0, samples_checked = 0;
  initial forever #5 clk = ~clk;
  les_ctrl_model ctl (.i_ref_clk(clk), .o_interlock(il), .o_shutter_req(sr),
    .o_reset_req(rr), .o_over_temp(ot), .o_pwm_cmd(pwm), .o_keep_alive(ka));
  les_sequencer #(.ENABLE_WAIT_CYC(W), .FILTER_CYC(3)) dut (.i_ref_clk(clk), .i_rst_b(rst_b),
    .i_interlock(il), .i_shutter_req(sr), .i_reset_req(rr), .i_over_temp(ot),
    .i_pwm_cmd(pwm), .i_keep_alive(ka), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(addr), .i_pwdata(wdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_rf_power_en(rfp), .o_rf_drive(rfd), .o_shutter_open(sho),
    .o_ready_lamp(rl), .o_shutter_lamp(sl), .o_intlk_lamp_green(gl), .o_ready_closed(rc),
    .o_shutter_closed(sc), .o_intlk_open_closed(ic));
  task give_verdict;
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      give_verdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // Power must not come before the full countdown, nor much after it.
  task automatic wait_power(input int lo);
    int n = 0;
    while (rfp !== 1'b1 && n < W + 60) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n >= lo && n < W + 60), 1);
    if (n >= W + 60) give_verdict();
  endtask : wait_power
  initial begin
    repeat (2) @(posedge clk);
    chk({rfp, ic}, 2'b01);
    rst_b <= 1'b1;
    apb(1'b0, LES_CTRL_OFS, '0);
    chk(q, LES_CTRL_RST);
    apb(1'b0, 8'h08, '0);
    chk({e, q[30:0]}, 32'h8000_0000);
    ctl.drive(4'b1000, 2'b10);
    wait_power(W);
    chk({rl, rc, gl, ic, rfd}, 5'b11100);
    ctl.drive(4'b1100, 2'b10);
    cyc(12);
    chk({rfd, sho, sl, sc}, 4'hF);
    apb(1'b0, LES_STAT_OFS, '0);
    chk(q & 32'h3F, 32'h3E);
    ctl.drive(4'b1000, 2'b01);
    cyc(12);
    chk({rfd, sho, sl, sc}, 4'b1000);
    ctl.drive(4'b1010, 2'b01);
    cyc(12);
    chk({rfp, rfd, rc}, 0);
    ctl.drive(4'b1000, 2'b01);
    wait_power(W);
    ctl.drive(4'b0000, 2'b01);
    ctl.drive(4'b1000, 2'b01);
    cyc(12);
    chk(rfp, 1);
    ctl.drive(4'b0000, 2'b01);
    cyc(12);
    chk({rfp, rl, gl, ic}, 4'b0001);
    ctl.drive(4'b1000, 2'b01);
    cyc(12);
    chk({rl, rfp, rfd}, 3'b100);
    wait_power(W - 12);
    apb(1'b1, LES_CTRL_OFS, 32'h1);
    apb(1'b0, LES_CTRL_OFS, '0);
    chk({rfp, q[30:0]}, 32'h1);
    apb(1'b1, LES_CTRL_OFS, '0);
    wait_power(W);
    ctl.drive(4'b1001, 2'b01);
    cyc(12);
    ctl.drive(4'b1010, 2'b01);
    cyc(12);
    ctl.drive(4'b1000, 2'b01);
    cyc(W + 40);
    chk({rfp, rc, rfd}, 0);
    @(posedge clk);
    rst_b <= 1'b0;
    cyc(2);
    chk({rfp, ic}, 2'b01);
    @(posedge clk);
    rst_b <= 1'b1;
    wait_power(W);
    give_verdict();
  end
endmodule : les_sequencer_test
